// ### src/dpr_defines.svh
// Purpose: Shared constants of the dual-port synchronous RAM port logic
// Assumes: Included by its bare name wherever the constants are needed
// Notes: Definitions only
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

// Word and lane layout
`define DPR_DATA_W 18
`define DPR_LANE_W 9
`define DPR_LANES 2
`define DPR_PORTS 2

// Address width range served by the logic
`define DPR_ADDR_MIN 16
`define DPR_ADDR_MAX 19
`define DPR_ADDR_DEF 16

// Reset values
`define DPR_MASK_RST 19'h7ffff
`define DPR_CNT_RST 19'h00000

// Read pipeline depth in cycles from sampled request to driven data
`define DPR_RD_LATENCY 3

`endif

// ### src/dpr_pkg.sv
// Purpose: Types of the dual-port synchronous RAM port logic
// Assumes: dpr_defines.svh is on the include path
// Notes: Nothing is imported; users write dpr_pkg::name
`include "dpr_defines.svh"

package dpr_pkg;

	// Counter and mask commands sampled with each cycle
	typedef enum logic [2:0] {
		CMD_HOLD = 3'b000,
		CMD_LOAD = 3'b001,
		CMD_INC = 3'b010,
		CMD_CNT_RST = 3'b011,
		CMD_MASK_LOAD = 3'b100,
		CMD_CNT_READ = 3'b101,
		CMD_MASK_READ = 3'b110,
		CMD_RETX = 3'b111
	} dpr_cmd_t;

	// One port's request pins for one cycle
	typedef struct packed {
		logic chip_select_low_active_n;
		logic chip_select_high_active;
		logic rw;
		logic [`DPR_LANES-1:0] lane_select;
		dpr_cmd_t cmd;
		logic mbx_set;
		logic mbx_clr;
		logic [`DPR_ADDR_MAX-1:0] addr;
		logic [`DPR_DATA_W-1:0] wdata;
	} dpr_req_t;

	// Read pipeline tag carried beside the data
	typedef struct packed {
		logic rd;
		logic [`DPR_LANES-1:0] lanes;
	} dpr_rtag_t;

endpackage : dpr_pkg

// ### src/dpr_top.sv
// Purpose: Port logic and array of a pipelined dual-port synchronous RAM with burst counters
// Assumes: Both host ports run on ref_clk_i; hosts are logic on that clock
// Notes: Function
// Function
// - Both ports reach any location independently in the same cycle
// - Control, address and write data are captured in input registers
// - Read data passes an output register after the array access
// - Burst counter in address path advances after a start address is loaded
// - Write strobe is one internal cycle, independent of read/write hold time
// - One deselected cycle powers the port down
// - One selected cycle is needed before outputs drive again
// - Address width is 16 to 19 bits by depth
// - Each port has its own byte-lane enables
// - Mask register selects which counter bits advance, setting the wrap point
// - Counter-wrap flag pulses when the masked counter wraps
// - Counter value can be read back on the address lines
// - Mask value can be read back on the address lines
// - Retransmit returns the counter to the masked block start
// - Mailbox flags let one port signal the other port's host
// - Global reset acts asynchronously and resets both ports
// - Only enabled lanes are read or written
// - Busy output asserts on conflicting accesses between ports
`include "dpr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dpr_top #(
	parameter int ADDR_W = `DPR_ADDR_DEF
) (
	// Clock and global reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Port requests, index 0 left, index 1 right
	input wire dpr_pkg::dpr_req_t [`DPR_PORTS-1:0] req_i,
	// Data lines
	output logic [`DPR_PORTS-1:0][`DPR_DATA_W-1:0] dq_o,
	output logic [`DPR_PORTS-1:0][`DPR_LANES-1:0] dq_oe_n_o,
	// Address lines in readback
	output logic [`DPR_PORTS-1:0][`DPR_ADDR_MAX-1:0] addr_o,
	output logic [`DPR_PORTS-1:0] addr_oe_n_o,
	// Status flags
	output logic [`DPR_PORTS-1:0] counter_wrap_flag_o,
	output logic [`DPR_PORTS-1:0] busy_o,
	output logic [`DPR_PORTS-1:0] mbx_flag_o,
	output logic [`DPR_PORTS-1:0] power_down_o
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [`DPR_ADDR_MAX-1:0] MASK_RST = `DPR_MASK_RST;
	localparam logic [`DPR_ADDR_MAX-1:0] CNT_RST = `DPR_CNT_RST;

	// Refuse widths outside the documented depth range at elaboration
	if (ADDR_W < `DPR_ADDR_MIN || ADDR_W > `DPR_ADDR_MAX) begin : g_bad_addr_w
		$error("dpr_top: ADDR_W must lie between 16 and 19");
	end

	// Storage array, one word per location
	logic [`DPR_DATA_W-1:0] mem [DEPTH];

	// Per-port results shared between ports and with the array
	logic [`DPR_PORTS-1:0] wr_stb;
	logic [`DPR_PORTS-1:0] rd_stb;
	logic [`DPR_PORTS-1:0][`DPR_LANES-1:0] lane_r;
	logic [`DPR_PORTS-1:0][ADDR_W-1:0] acc_addr;
	logic [`DPR_PORTS-1:0][`DPR_DATA_W-1:0] wdata_r;
	logic [`DPR_PORTS-1:0] mbx_set_r;
	logic [`DPR_PORTS-1:0] mbx_clr_r;
	logic [`DPR_PORTS-1:0][`DPR_DATA_W-1:0] rd_q;

	genvar p;
	generate
		for (p = 0; p < `DPR_PORTS; p++) begin : g_port
			dpr_pkg::dpr_req_t in_r;
			logic in_vld_r;
			logic pd_r;
			logic [ADDR_W-1:0] cnt_r;
			logic [ADDR_W-1:0] cnt_nxt;
			logic [ADDR_W-1:0] mask_r;
			logic [ADDR_W-1:0] mask_nxt;
			logic [ADDR_W-1:0] start_r;
			logic [ADDR_W-1:0] start_nxt;
			logic [ADDR_W-1:0] in_addr;
			logic [ADDR_W-1:0] adv;
			logic [ADDR_W-1:0] inc_addr;
			logic [ADDR_W-1:0] block_start;
			logic sel;
			logic wrap;
			logic do_inc;
			logic do_load;
			logic mem_op;
			dpr_pkg::dpr_rtag_t tag1_r;
			dpr_pkg::dpr_rtag_t tag2_r;
			logic [`DPR_DATA_W-1:0] dq_r;
			logic [`DPR_LANES-1:0] dq_oe_n_r;
			logic [`DPR_ADDR_MAX-1:0] addr_out_r;
			logic addr_oe_n_r;
			logic wrap_r;

			// Input registers sample every pin on the clock edge
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					in_r <= '0;
					in_vld_r <= 1'b0;
				end else begin
					in_r <= req_i[p];
					in_vld_r <= 1'b1;
				end
			end

			// Chip selects and command decode from the captured request
			assign sel = in_vld_r && !in_r.chip_select_low_active_n && in_r.chip_select_high_active;
			assign in_addr = in_r.addr[ADDR_W-1:0];
			assign do_load = sel && in_r.cmd == dpr_pkg::CMD_LOAD;
			assign do_inc = sel && in_r.cmd == dpr_pkg::CMD_INC;
			assign mem_op = sel && (in_r.cmd == dpr_pkg::CMD_HOLD || in_r.cmd == dpr_pkg::CMD_LOAD
				|| in_r.cmd == dpr_pkg::CMD_INC);

			// Masked increment: only mask bits advance, the rest stay put
			assign adv = (cnt_r & mask_r) + {{(ADDR_W-1){1'b0}}, 1'b1};
			assign wrap = (cnt_r & mask_r) == mask_r;
			assign block_start = (cnt_r & ~mask_r) | (start_r & mask_r);
			assign inc_addr = wrap ? block_start : ((cnt_r & ~mask_r) | (adv & mask_r));

			// Address used for this cycle's array access
			assign acc_addr[p] = do_load ? in_addr : (do_inc ? inc_addr : cnt_r);

			// Counter, start and mask next values
			always_comb begin
				cnt_nxt = cnt_r;
				start_nxt = start_r;
				mask_nxt = mask_r;
				if (sel) begin
					unique case (in_r.cmd)
						dpr_pkg::CMD_HOLD: begin
							cnt_nxt = cnt_r;
						end
						dpr_pkg::CMD_LOAD: begin
							cnt_nxt = in_addr;
							start_nxt = in_addr;
						end
						dpr_pkg::CMD_INC: begin
							cnt_nxt = inc_addr;
						end
						dpr_pkg::CMD_CNT_RST: begin
							cnt_nxt = CNT_RST[ADDR_W-1:0];
							start_nxt = CNT_RST[ADDR_W-1:0];
						end
						dpr_pkg::CMD_MASK_LOAD: begin
							mask_nxt = in_addr;
						end
						dpr_pkg::CMD_CNT_READ: begin
							cnt_nxt = cnt_r;
						end
						dpr_pkg::CMD_MASK_READ: begin
							cnt_nxt = cnt_r;
						end
						dpr_pkg::CMD_RETX: begin
							cnt_nxt = block_start;
						end
					endcase
				end
			end

			// Counter state, reset by the global reset
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					cnt_r <= CNT_RST[ADDR_W-1:0];
					start_r <= CNT_RST[ADDR_W-1:0];
					mask_r <= MASK_RST[ADDR_W-1:0];
				end else begin
					cnt_r <= cnt_nxt;
					start_r <= start_nxt;
					mask_r <= mask_nxt;
				end
			end

			// Strobes toward the array: one per captured cycle
			assign wr_stb[p] = mem_op && !in_r.rw;
			assign rd_stb[p] = mem_op && in_r.rw;
			assign lane_r[p] = in_r.lane_select;
			assign wdata_r[p] = in_r.wdata;
			assign mbx_set_r[p] = sel && in_r.mbx_set;
			assign mbx_clr_r[p] = sel && in_r.mbx_clr;

			// Power-down follows any deselected cycle; one selected cycle wakes it
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					pd_r <= 1'b1;
				end else if (in_vld_r) begin
					pd_r <= !sel;
				end
			end

			// Read tag pipeline beside the array and output registers
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					tag1_r <= '0;
					tag2_r <= '0;
				end else begin
					tag1_r <= '{rd: rd_stb[p], lanes: in_r.lane_select};
					tag2_r <= tag1_r;
				end
			end

			// Output register: only enabled lanes are loaded and driven
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					dq_r <= '0;
					dq_oe_n_r <= '1;
				end else begin
					for (int l = 0; l < `DPR_LANES; l++) begin
						if (tag1_r.rd && tag1_r.lanes[l]) begin
							dq_r[l*`DPR_LANE_W +: `DPR_LANE_W] <= rd_q[p][l*`DPR_LANE_W +: `DPR_LANE_W];
						end
						dq_oe_n_r[l] <= !(tag1_r.rd && tag1_r.lanes[l]);
					end
				end
			end

			// Readback of counter or mask onto the address lines for one cycle
			always_ff @(posedge ref_clk_i or posedge reset_i) begin
				if (reset_i) begin
					addr_out_r <= '0;
					addr_oe_n_r <= 1'b1;
					wrap_r <= 1'b0;
				end else begin
					addr_out_r <= '0;
					addr_oe_n_r <= 1'b1;
					if (sel && in_r.cmd == dpr_pkg::CMD_CNT_READ) begin
						addr_out_r[ADDR_W-1:0] <= cnt_r;
						addr_oe_n_r <= 1'b0;
					end
					if (sel && in_r.cmd == dpr_pkg::CMD_MASK_READ) begin
						addr_out_r[ADDR_W-1:0] <= mask_r;
						addr_oe_n_r <= 1'b0;
					end
					wrap_r <= do_inc && wrap;
				end
			end

			// Port outputs
			assign dq_o[p] = dq_r;
			assign dq_oe_n_o[p] = dq_oe_n_r;
			assign addr_o[p] = addr_out_r;
			assign addr_oe_n_o[p] = addr_oe_n_r;
			assign counter_wrap_flag_o[p] = wrap_r;
			assign power_down_o[p] = pd_r;
		end
	endgenerate

	// Array writes, lane by lane; where both ports write the same lane of a word, port 1's data is kept
	always_ff @(posedge ref_clk_i) begin
		for (int q = 0; q < `DPR_PORTS; q++) begin
			for (int l = 0; l < `DPR_LANES; l++) begin
				if (wr_stb[q] && lane_r[q][l]) begin
					mem[acc_addr[q]][l*`DPR_LANE_W +: `DPR_LANE_W] <= wdata_r[q][l*`DPR_LANE_W +: `DPR_LANE_W];
				end
			end
		end
	end

	// Array reads, each port independently
	always_ff @(posedge ref_clk_i) begin
		for (int q = 0; q < `DPR_PORTS; q++) begin
			if (rd_stb[q]) begin
				rd_q[q] <= mem[acc_addr[q]];
			end
		end
	end

	// Conflict: same address, both active, at least one writing
	logic collide;
	assign collide = (wr_stb[0] || wr_stb[1]) && (wr_stb[0] || rd_stb[0]) && (wr_stb[1] || rd_stb[1])
		&& acc_addr[0] == acc_addr[1];

	// Busy flags and mailbox flags; a set wins over a clear in the same cycle
	logic [`DPR_PORTS-1:0] busy_r;
	logic [`DPR_PORTS-1:0] mbx_r;
	logic [`DPR_PORTS-1:0] mbx_nxt;
	assign mbx_nxt[0] = mbx_set_r[1] || (mbx_r[0] && !mbx_clr_r[0]);
	assign mbx_nxt[1] = mbx_set_r[0] || (mbx_r[1] && !mbx_clr_r[1]);

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_r <= '0;
			mbx_r <= '0;
		end else begin
			busy_r <= {`DPR_PORTS{collide}};
			mbx_r <= mbx_nxt;
		end
	end

	assign busy_o = busy_r;
	assign mbx_flag_o = mbx_r;

endmodule : dpr_top

`default_nettype wire

// ### test/dpr_host.sv
// Purpose: Host model on one RAM port
// Assumes: Requests staged at a rising edge
// Notes: Idle cycles stay selected and access no lane
`timescale 1ns/1ps
`default_nettype none
module dpr_host (
	// Clock
	input wire logic ref_clk_i,
	// Port request pins
	output wire dpr_pkg::dpr_req_t req_o
);
	dpr_pkg::dpr_req_t r = '{1'b0, 1'b1, 1'b1, 2'h0, dpr_pkg::CMD_HOLD, 1'b0, 1'b0, 19'h0, 18'h0};
	dpr_pkg::dpr_req_t nxt;
	logic pend = 1'b0;
	assign req_o = r;
	// Stage one request for the next falling edge
	task put(input dpr_pkg::dpr_req_t q);
		nxt = q;
		pend = 1'b1;
	endtask : put
	// Apply staged request, else stay selected and flip released lines
	always @(negedge ref_clk_i) begin
		r <= pend ? nxt : '{1'b0, 1'b1, 1'b1, 2'h0, dpr_pkg::CMD_HOLD, 1'b0, 1'b0, ~r.addr, ~r.wdata};
		pend <= 1'b0;
	end
endmodule : dpr_host
`default_nettype wire

// ### test/dpr_top_sva.sv
// Purpose: Port properties of the dual-port RAM
// Assumes: One clock; sees only top ports
// Notes: Bound after the module
`include "dpr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dpr_chk #(
	parameter int ADDR_W = `DPR_ADDR_DEF
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Watched ports
	input wire dpr_pkg::dpr_req_t [`DPR_PORTS-1:0] req_i,
	input wire logic [`DPR_PORTS-1:0][`DPR_LANES-1:0] dq_oe_n_o,
	input wire logic [`DPR_PORTS-1:0][`DPR_ADDR_MAX-1:0] addr_o,
	input wire logic [`DPR_PORTS-1:0] addr_oe_n_o,
	input wire logic [`DPR_PORTS-1:0] counter_wrap_flag_o,
	input wire logic [`DPR_PORTS-1:0] busy_o,
	input wire logic [`DPR_PORTS-1:0] mbx_flag_o,
	input wire logic [`DPR_PORTS-1:0] power_down_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic [1:0] sel, mem, inc;
	logic coll;
	// Per-port request decode and properties
	for (genvar p = 0; p < 2; p++) begin : g_port
		assign sel[p] = !req_i[p].chip_select_low_active_n && req_i[p].chip_select_high_active;
		assign inc[p] = sel[p] && req_i[p].cmd == dpr_pkg::CMD_INC;
		assign mem[p] = sel[p] && req_i[p].cmd inside {dpr_pkg::CMD_HOLD, dpr_pkg::CMD_LOAD, dpr_pkg::CMD_INC};
		sequence s_mload;
			sel[p] && req_i[p].cmd == dpr_pkg::CMD_MASK_LOAD;
		endsequence
		sequence s_mread;
			sel[p] && req_i[p].cmd == dpr_pkg::CMD_MASK_READ;
		endsequence
		a_read_lane_oe: assert property (mem[p] && req_i[p].rw |-> ##3 dq_oe_n_o[p] == ~$past(req_i[p].lane_select, 3))
			else $error("read lane enables wrong");
		a_power_down: assert property (!sel[p] |-> ##2 power_down_o[p])
			else $error("no power down after deselect");
		a_power_up: assert property (sel[p] |-> ##2 !power_down_o[p])
			else $error("still powered down");
		a_count_readback: assert property (sel[p] && req_i[p].cmd == dpr_pkg::CMD_CNT_READ |-> ##2 !addr_oe_n_o[p])
			else $error("counter readback not driven");
		a_mask_readback: assert property (s_mload ##1 s_mread |-> ##2 addr_o[p][ADDR_W-1:0] == $past(req_i[p].addr[ADDR_W-1:0], 3))
			else $error("mask readback wrong");
		a_wrap_cause: assert property (counter_wrap_flag_o[p] |-> $past(inc[p], 2))
			else $error("wrap flag without advance");
		a_mbx_set: assert property (sel[p] && req_i[p].mbx_set |-> ##2 mbx_flag_o[1-p])
			else $error("mailbox flag not set");
	end
	// Same address, both ports, at least one write
	assign coll = mem[0] && mem[1] && req_i[0].cmd == dpr_pkg::CMD_LOAD && req_i[1].cmd == dpr_pkg::CMD_LOAD
		&& req_i[0].addr[ADDR_W-1:0] == req_i[1].addr[ADDR_W-1:0] && !(req_i[0].rw && req_i[1].rw);
	a_busy_both: assert property (coll |-> ##2 busy_o == 2'h3)
		else $error("collision not flagged");
	a_reset_state: assert property ($fell(reset_i) |-> power_down_o == 2'h3 && mbx_flag_o == 2'h0)
		else $error("reset state wrong");
endmodule : dpr_chk
bind dpr_top dpr_chk #(.ADDR_W(ADDR_W)) dpr_chk_i (.ref_clk_i, .reset_i, .req_i, .dq_oe_n_o, .addr_o, .addr_oe_n_o,
	.counter_wrap_flag_o, .busy_o, .mbx_flag_o, .power_down_o);
`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench of the dual-port RAM ports
// Assumes: Requests reach the pins at falling edges
// Notes: Sampling waits follow the read and flag latencies
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	wire dpr_pkg::dpr_req_t [1:0] req;
	logic [1:0][17:0] dq;
	logic [1:0][1:0] dq_oe_n;
	logic [1:0][18:0] addr;
	logic [1:0] addr_oe_n, wrap, busy, mbx, pdn;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	dpr_pkg::dpr_req_t r;
	dpr_host dpr_host_i [1:0] (.ref_clk_i(ref_clk_i), .req_o(req));
	dpr_top dpr_top_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req), .dq_o(dq), .dq_oe_n_o(dq_oe_n),
		.addr_o(addr), .addr_oe_n_o(addr_oe_n), .counter_wrap_flag_o(wrap), .busy_o(busy), .mbx_flag_o(mbx),
		.power_down_o(pdn));
	// Clock and hang guard
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			mismatches++;
			end_of_test();
		end
	end
	task chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic dpr_pkg::dpr_req_t mk(input dpr_pkg::dpr_cmd_t c, input logic rw, input logic [1:0] ln,
		input logic [18:0] a, input logic [17:0] d);
		return '{1'b0, 1'b1, rw, ln, c, 1'b0, 1'b0, a, d};
	endfunction : mk
	// Stage requests on the ports picked by pm
	task op(input logic [1:0] pm, input dpr_pkg::dpr_req_t a, input dpr_pkg::dpr_req_t b);
		@(posedge ref_clk_i);
		if (pm[0]) dpr_host_i[0].put(a);
		if (pm[1]) dpr_host_i[1].put(b);
	endtask : op
	task wt(input int n);
		repeat (n) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask : wt
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("power_down", pdn, 2'h3);
		chk("dq_oe", dq_oe_n, 4'hf);
		reset_i = 1'b0;
		op(2'h1, mk(dpr_pkg::CMD_LOAD, 1'b0, 2'h3, 19'h5, 18'h12345), '0);
		op(2'h1, mk(dpr_pkg::CMD_LOAD, 1'b0, 2'h1, 19'h5, 18'h00aaa), '0);
		op(2'h3, mk(dpr_pkg::CMD_LOAD, 1'b0, 2'h3, 19'h6, 18'h2a5a5), mk(dpr_pkg::CMD_LOAD, 1'b1, 2'h3, 19'h5, 18'h0));
		wt(3);
		chk("dq_right", dq[1], 19'h122aa);
		op(2'h2, '0, mk(dpr_pkg::CMD_LOAD, 1'b1, 2'h2, 19'h6, 18'h0));
		wt(3);
		chk("dq_lane", dq[1], (19'h2a5a5 & 19'h3fe00) | 19'h0aa);
		chk("dq_oe_lane", dq_oe_n[1], 2'h1);
		op(2'h1, mk(dpr_pkg::CMD_MASK_LOAD, 1'b1, 2'h0, 19'h3, 18'h0), '0);
		op(2'h1, mk(dpr_pkg::CMD_MASK_READ, 1'b1, 2'h0, 19'h0, 18'h0), '0);
		wt(2);
		chk("mask_back", addr[0], 19'h3);
		op(2'h1, mk(dpr_pkg::CMD_LOAD, 1'b0, 2'h3, 19'h8, 18'h0), '0);
		for (int i = 1; i < 5; i++) op(2'h1, mk(dpr_pkg::CMD_INC, 1'b0, 2'h3, 19'h7ffff, 18'(i)), '0);
		wt(2);
		chk("wrap_flag", wrap[0], 1'b1);
		op(2'h1, mk(dpr_pkg::CMD_INC, 1'b1, 2'h0, 19'h0, 18'h0), '0);
		op(2'h1, mk(dpr_pkg::CMD_RETX, 1'b1, 2'h0, 19'h0, 18'h0), '0);
		op(2'h1, mk(dpr_pkg::CMD_CNT_READ, 1'b1, 2'h0, 19'h0, 18'h0), '0);
		wt(2);
		chk("count_back", addr[0], 19'h8);
		for (int i = 0; i < 4; i++) begin
			op(2'h1, mk(dpr_pkg::CMD_LOAD, 1'b1, 2'h3, 19'(8 + i), 18'h0), '0);
			wt(3);
			chk("burst_word", dq[0], (i == 0) ? 19'h4 : 19'(i));
		end
		op(2'h3, mk(dpr_pkg::CMD_LOAD, 1'b0, 2'h3, 19'h7, 18'h1), mk(dpr_pkg::CMD_LOAD, 1'b1, 2'h3, 19'h7, 18'h0));
		wt(2);
		chk("busy", busy, 2'h3);
		r = mk(dpr_pkg::CMD_HOLD, 1'b1, 2'h0, 19'h0, 18'h0);
		r.mbx_set = 1'b1;
		op(2'h1, r, '0);
		wt(2);
		chk("mbx_set", mbx[1], 1'b1);
		r.mbx_set = 1'b0;
		r.mbx_clr = 1'b1;
		op(2'h2, '0, r);
		wt(2);
		chk("mbx_clr", mbx[1], 1'b0);
		r.mbx_clr = 1'b0;
		r.chip_select_high_active = 1'b0;
		op(2'h1, r, '0);
		wt(2);
		chk("power_down", pdn[0], 1'b1);
		wt(1);
		chk("power_up", pdn[0], 1'b0);
		reset_i = 1'b1;
		wt(1);
		chk("reset_again", pdn, 2'h3);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
